/* rtl/scpm_pkg.sv */
// constants for stack check and program space map
package scpm_pkg;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned PROG_W     = 24;
  localparam int unsigned PAGE_W     = 8;
  localparam int unsigned PC_W       = 23;
  localparam int unsigned SR_LOW_W   = 8;
  localparam int unsigned STACK_STEP = 2;
  localparam logic [15:0] STACK_FLOOR = 16'h0800;
  localparam logic [15:0] SP_RESET    = 16'h0800;
  localparam int unsigned EA_TOP_BIT  = 15;
  localparam int unsigned PAGE_TOP_BIT = 7;
  localparam int unsigned VIS_EN_BIT  = 2;
  localparam int unsigned PROG_USER_BIT = 23;

  typedef enum logic [1:0] {
    SCPM_STK_NONE = 2'b00,
    SCPM_STK_PUSH = 2'b01,
    SCPM_STK_POP  = 2'b10,
    SCPM_STK_REF  = 2'b11
  } scpm_stk_op_t;

  typedef enum logic [1:0] {
    SCPM_PA_FETCH = 2'b00,
    SCPM_PA_TABLE = 2'b01,
    SCPM_PA_WIN   = 2'b10,
    SCPM_PA_NONE  = 2'b11
  } scpm_pa_kind_t;
endpackage

/* rtl/scpm_stack_check.sv */
// stack bound comparator for one generated stack address
`timescale 1ns/1ps
`default_nettype none
module scpm_stack_check (
  input  wire logic [15:0] i_addr,     // generated stack address
  input  wire logic [15:0] i_limit,    // stack upper bound, bit 0 clear
  input  wire logic        i_check,    // address is a stack reference
  input  wire logic        i_push,     // reference is a push
  output logic             o_over,     // upper bound crossed
  output logic             o_under     // below stack floor
);
  // a push writing at the limit is fine; only beyond it traps
  assign o_over  = i_check && i_push && (i_addr > i_limit);
  assign o_under = i_check && (i_addr < scpm_pkg::STACK_FLOOR);
endmodule
`default_nettype wire

/* rtl/scpm_prog_map.sv */
// program-space address builder for fetch, table and window
`timescale 1ns/1ps
`default_nettype none
module scpm_prog_map (
  input  wire logic [1:0]  i_kind,      // access kind
  input  wire logic [22:0] i_pc,        // program counter
  input  wire logic [15:0] i_ea,        // data effective address
  input  wire logic [7:0]  i_tbl_page,  // table page value
  input  wire logic [7:0]  i_vis_page,  // visibility page value
  output logic [23:0]      o_addr,      // program address
  output logic             o_config     // targets configuration space
);
  always_comb begin
    o_addr   = 24'h00_0000;
    o_config = 1'b0;
    unique case (scpm_pkg::scpm_pa_kind_t'(i_kind))
      scpm_pkg::SCPM_PA_FETCH: begin
        o_addr = {1'b0, i_pc[22:1], 1'b0};
      end
      scpm_pkg::SCPM_PA_TABLE: begin
        o_addr   = {i_tbl_page, i_ea};
        o_config = i_tbl_page[scpm_pkg::PAGE_TOP_BIT];
      end
      scpm_pkg::SCPM_PA_WIN: begin
        // page bit 0 lands on bit 15, ea bit 15 is dropped
        o_addr = {1'b0, i_vis_page, i_ea[14:1], 1'b0};
      end
      scpm_pkg::SCPM_PA_NONE: begin
        o_addr = 24'h00_0000;
      end
    endcase
  end
endmodule
`default_nettype wire

/* rtl/scpm_top.sv */
// stack pointer management, stack traps and program space addressing
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module scpm_top #(
  parameter int unsigned DATA_W = scpm_pkg::DATA_W   // data word width
) (
  input  wire logic              i_clock,         // core clock, 10 MHz
  input  wire logic              i_rst_b,         // async reset, active low
  // stack pointer and limit writes
  input  wire logic              i_sp_wr,         // load stack pointer
  input  wire logic [15:0]       i_sp_wdata,      // stack pointer value
  input  wire logic              i_limit_wr,      // load stack limit
  input  wire logic [15:0]       i_limit_wdata,   // stack limit value
  // stack operations
  input  wire logic [1:0]        i_stk_op,        // none, push, pop, reference
  input  wire logic [15:0]       i_stk_ref_ea,    // ea formed from stack pointer
  input  wire logic              i_push_call,     // push is a call's counter
  input  wire logic              i_push_exc,      // push is an exception counter
  input  wire logic [22:0]       i_pc,            // program counter
  input  wire logic [7:0]        i_status_low,    // status low byte
  input  wire logic [15:0]       i_push_data,     // ordinary push data
  // program space access
  input  wire logic              i_fetch,         // instruction fetch
  input  wire logic              i_tbl_rd,        // table read op
  input  wire logic              i_tbl_wr,        // table write op
  input  wire logic              i_tbl_high,      // table op on upper part
  input  wire logic              i_tbl_byte,      // table byte op
  input  wire logic [15:0]       i_tbl_wdata,     // table write data
  input  wire logic              i_data_rd,       // data space read
  input  wire logic              i_data_wr,       // data space write
  input  wire logic [15:0]       i_ea,            // data effective address
  input  wire logic [7:0]        i_tbl_page,      // table page register
  input  wire logic [7:0]        i_vis_page,      // visibility page register
  input  wire logic [15:0]       i_core_ctrl,     // core control register
  input  wire logic [23:0]       i_prog_rdata,    // program word from memory
  // stack side outputs
  output logic [15:0]            o_sp,            // stack pointer
  output logic [15:0]            o_limit,         // stack limit, bit 0 zero
  output logic [15:0]            o_stk_addr,      // data address of stack access
  output logic                   o_stk_wr,        // stack write strobe
  output logic                   o_stk_rd,        // stack read strobe
  output logic [DATA_W-1:0]      o_stk_wdata,     // stack write word
  output logic [7:0]             o_stk_wdata_hi,  // counter upper word high byte
  output logic                   o_stack_trap,    // stack error trap request
  output logic                   o_trap_over,     // trap cause overflow
  output logic                   o_trap_under,    // trap cause underflow
  // program space outputs
  output logic [23:0]            o_prog_addr,     // program address
  output logic                   o_prog_rd,       // program read strobe
  output logic                   o_prog_wr,       // program write strobe
  output logic [23:0]            o_prog_wdata,    // program write word
  output logic [2:0]             o_prog_be,       // program byte lanes
  output logic                   o_prog_config,   // access in config space
  output logic                   o_tbl_reject,    // table write refused
  output logic                   o_win_hit,       // window mapped read
  output logic                   o_win_wr_block,  // write into window ignored
  output logic [15:0]            o_rdata,         // program data to datapath
  output logic                   o_rvalid         // o_rdata valid
);
  // ----------------------------------------------------------------
  // stack pointer
  // ----------------------------------------------------------------
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [15:0] limit_reg;
  logic        push_act;
  logic        pop_act;
  logic        ref_act;
  logic [15:0] stk_addr;

  assign push_act = (i_stk_op == scpm_pkg::SCPM_STK_PUSH);
  assign pop_act  = (i_stk_op == scpm_pkg::SCPM_STK_POP);
  assign ref_act  = (i_stk_op == scpm_pkg::SCPM_STK_REF);

  // push writes at the pointer, pop reads one word below it
  always_comb begin
    stk_addr = sp_reg;
    sp_next  = sp_reg;
    if (i_sp_wr) begin
      sp_next = {i_sp_wdata[15:1], 1'b0};
    end else if (push_act) begin
      sp_next = sp_reg + 16'(scpm_pkg::STACK_STEP);
    end else if (pop_act) begin
      stk_addr = sp_reg - 16'(scpm_pkg::STACK_STEP);
      sp_next  = stk_addr;
    end
    if (ref_act) begin
      stk_addr = i_stk_ref_ea;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp_reg <= scpm_pkg::SP_RESET;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // limit has no reset value on purpose
  always_ff @(posedge i_clock) begin
    if (i_limit_wr) begin
      limit_reg <= {i_limit_wdata[15:1], 1'b0};
    end
  end

  assign o_sp    = sp_reg;
  assign o_limit = {limit_reg[15:1], 1'b0};

  // ----------------------------------------------------------------
  // stack traps
  // ----------------------------------------------------------------
  logic chk_over;
  logic chk_under;

  scpm_stack_check u_check (
    .i_addr  (stk_addr),
    .i_limit (o_limit),
    .i_check (push_act || pop_act || ref_act),
    .i_push  (push_act),
    .o_over  (chk_over),
    .o_under (chk_under)
  );

  assign o_stack_trap = chk_over || chk_under;
  assign o_trap_over  = chk_over;
  assign o_trap_under = chk_under;

  // ----------------------------------------------------------------
  // stack data path
  // ----------------------------------------------------------------
  logic [15:0] push_word;
  logic [7:0]  push_hi;
  logic [6:0]  pc_top;
  logic [15:0] exc_upper;
  logic        push_go;
  logic        pop_go;

  // a pointer load in the same cycle wins over a push or pop
  assign push_go = push_act && !i_sp_wr;
  assign pop_go  = pop_act && !i_sp_wr;

  assign pc_top = i_pc[22:16];

  // exception frame word: status low byte beside the counter top part
  assign exc_upper = {i_status_low, 1'b0, pc_top};

  always_comb begin
    push_word = i_push_data;
    push_hi   = 8'h00;
    if (i_push_call) begin
      push_word = i_pc[15:0];
      push_hi   = {1'b0, pc_top};
    end else if (i_push_exc) begin
      push_word = exc_upper;
      push_hi   = {1'b0, pc_top};
    end
  end

  // strobes and address; strobes withheld on a trapped push or pop, address always registered
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_stk_addr <= 16'h0000;
      o_stk_wr   <= 1'b0;
      o_stk_rd   <= 1'b0;
    end else begin
      o_stk_addr <= stk_addr;
      o_stk_wr   <= push_go && !o_stack_trap;
      o_stk_rd   <= pop_go && !o_stack_trap;
    end
  end

  // write data for the stack memory
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_stk_wdata    <= '0;
      o_stk_wdata_hi <= 8'h00;
    end else begin
      o_stk_wdata    <= DATA_W'(push_word);
      o_stk_wdata_hi <= push_hi;
    end
  end

  // ----------------------------------------------------------------
  // program space address
  // ----------------------------------------------------------------
  logic tbl_act;
  logic vis_en;
  logic win_act;
  logic [1:0]  pa_kind;
  logic [23:0] pa_addr;
  logic        pa_config;

  assign tbl_act = i_tbl_rd || i_tbl_wr;
  assign vis_en  = i_core_ctrl[scpm_pkg::VIS_EN_BIT];
  assign win_act = vis_en && i_ea[scpm_pkg::EA_TOP_BIT] && !tbl_act && (i_data_rd || i_data_wr);

  // table wins over window, window over fetch
  always_comb begin
    if (tbl_act) begin
      pa_kind = scpm_pkg::SCPM_PA_TABLE;
    end else if (win_act) begin
      pa_kind = scpm_pkg::SCPM_PA_WIN;
    end else if (i_fetch) begin
      pa_kind = scpm_pkg::SCPM_PA_FETCH;
    end else begin
      pa_kind = scpm_pkg::SCPM_PA_NONE;
    end
  end

  scpm_prog_map u_map (
    .i_kind     (pa_kind),
    .i_pc       (i_pc),
    .i_ea       (i_ea),
    .i_tbl_page (i_tbl_page),
    .i_vis_page (i_vis_page),
    .o_addr     (pa_addr),
    .o_config   (pa_config)
  );

  logic tbl_rej;
  logic win_rd;
  logic [2:0] be;
  assign tbl_rej = i_tbl_wr && pa_config;
  assign win_rd  = win_act && i_data_rd && !i_data_wr;

  // byte lanes: byte op takes lane 0 or 1 by ea bit 0, word op lanes 0 and 1, upper part is lane 2
  always_comb begin
    if (i_tbl_high) begin
      be = 3'b100;
    end else if (i_tbl_byte) begin
      be = i_ea[0] ? 3'b010 : 3'b001;
    end else begin
      be = 3'b011;
    end
  end

  // program-side strobes and address
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prog_addr  <= 24'h00_0000;
      o_prog_rd    <= 1'b0;
      o_prog_wr    <= 1'b0;
      o_prog_wdata <= 24'h00_0000;
      o_prog_be    <= 3'b000;
    end else begin
      o_prog_addr  <= pa_addr;
      o_prog_rd    <= i_tbl_rd || win_rd || (i_fetch && !tbl_act && !win_act);
      o_prog_wr    <= i_tbl_wr && !tbl_rej;
      // table write data repeats its low byte in the upper lane
      o_prog_wdata <= {i_tbl_wdata[7:0], i_tbl_wdata};
      o_prog_be    <= tbl_act ? be : 3'b111;
    end
  end

  // access flags for the datapath
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_prog_config  <= 1'b0;
      o_tbl_reject   <= 1'b0;
      o_win_hit      <= 1'b0;
      o_win_wr_block <= 1'b0;
    end else begin
      o_prog_config  <= pa_config;
      o_tbl_reject   <= tbl_rej;
      o_win_hit      <= win_rd;
      o_win_wr_block <= win_act && i_data_wr;
    end
  end

  // ----------------------------------------------------------------
  // read return
  // ----------------------------------------------------------------
  logic rd_win_q;
  logic rd_tbl_q;
  logic rd_hi_q;
  logic rd_byte_q;
  logic rd_odd_q;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_win_q  <= 1'b0;
      rd_tbl_q  <= 1'b0;
      rd_hi_q   <= 1'b0;
      rd_byte_q <= 1'b0;
      rd_odd_q  <= 1'b0;
    end else begin
      rd_win_q  <= win_rd;
      rd_tbl_q  <= i_tbl_rd;
      rd_hi_q   <= i_tbl_high;
      rd_byte_q <= i_tbl_byte;
      rd_odd_q  <= i_ea[0];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata  <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= rd_win_q || rd_tbl_q;
      if (rd_win_q) begin
        o_rdata <= i_prog_rdata[15:0];
      end else if (rd_tbl_q && rd_hi_q) begin
        // upper byte of the high part is always zero
        o_rdata <= (rd_byte_q && rd_odd_q) ? 16'h0000
                   : {8'h00, i_prog_rdata[23:16]};
      end else if (rd_tbl_q && rd_byte_q) begin
        o_rdata <= {8'h00, rd_odd_q ? i_prog_rdata[15:8] : i_prog_rdata[7:0]};
      end else if (rd_tbl_q) begin
        o_rdata <= i_prog_rdata[15:0];
      end
    end
  end
endmodule
`default_nettype wire

/* tb/scpm_prog_mem.sv */
// program memory model answering reads in the strobe cycle
`timescale 1ns/1ps
`default_nettype none
module scpm_prog_mem (
  input  wire logic        i_clock,  // core clock
  input  wire logic        i_rd,     // read strobe
  input  wire logic [23:0] i_addr,   // program address
  output logic      [23:0] o_rdata   // program word
);
  logic [23:0] last_reg = 24'h00_0000;
  // word pattern from address; idle bus shows the inverse of the last word
  assign o_rdata = i_rd ? {i_addr[7:0], i_addr[15:0] ^ 16'h5a5a} : ~last_reg;
  always @(posedge i_clock) last_reg <= o_rdata;
endmodule
`default_nettype wire

/* tb/scpm_top_props.sv */
// concurrent checks on the stack and program-space ports
`timescale 1ns/1ps
`default_nettype none
module scpm_top_props #(
  parameter int unsigned DATA_W = 16  // data word width
) (
  input wire logic        i_clock,         // clock
  input wire logic        i_rst_b,         // reset
  input wire logic        i_sp_wr,         // pointer load
  input wire logic        i_limit_wr,      // limit load
  input wire logic [15:0] i_limit_wdata,   // limit value
  input wire logic [1:0]  i_stk_op,        // stack op
  input wire logic [15:0] i_stk_ref_ea,    // stack ea
  input wire logic        i_fetch,         // fetch
  input wire logic        i_tbl_rd,        // table read
  input wire logic        i_tbl_wr,        // table write
  input wire logic        i_data_rd,       // data read
  input wire logic        i_data_wr,       // data write
  input wire logic [15:0] i_ea,            // data ea
  input wire logic [7:0]  i_tbl_page,      // table page
  input wire logic [7:0]  i_vis_page,      // window page
  input wire logic [15:0] i_core_ctrl,     // core control
  input wire logic [23:0] i_prog_rdata,    // program word
  input wire logic [15:0] o_sp,            // pointer
  input wire logic [15:0] o_limit,         // limit
  input wire logic [15:0] o_stk_addr,      // stack address
  input wire logic        o_stk_wr,        // stack write
  input wire logic        o_stk_rd,        // stack read
  input wire logic        o_stack_trap,    // trap
  input wire logic        o_trap_over,     // overflow
  input wire logic        o_trap_under,    // underflow
  input wire logic [23:0] o_prog_addr,     // program address
  input wire logic        o_prog_rd,       // program read
  input wire logic        o_prog_wr,       // program write
  input wire logic        o_prog_config,   // config space
  input wire logic        o_tbl_reject,    // write refused
  input wire logic        o_win_hit,       // window read
  input wire logic        o_win_wr_block,  // window write dropped
  input wire logic [15:0] o_rdata,         // read data
  input wire logic        o_rvalid         // read data valid
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  logic sp_free;
  assign sp_free = !i_sp_wr && !o_stack_trap;
  sequence s_push;
    i_stk_op == 2'b01 && sp_free;
  endsequence
  sequence s_pop;
    i_stk_op == 2'b10 && sp_free;
  endsequence
  sequence s_win_req;
    i_data_rd && !i_data_wr && i_ea[15] && i_core_ctrl[2] && !i_tbl_rd && !i_tbl_wr && !i_fetch;
  endsequence
  sequence s_win_data;
    o_rvalid && o_rdata == $past(i_prog_rdata[15:0]);
  endsequence
  a_push_post_inc: assert property (
    s_push |=> o_stk_wr && o_stk_addr == $past(o_sp) && o_sp == $past(o_sp) + 16'h0002)
    else $error("push address or pointer step wrong");
  a_pop_pre_dec: assert property (
    s_pop |=> o_stk_rd && o_stk_addr == $past(o_sp) - 16'h0002 && o_sp == o_stk_addr)
    else $error("pop address or pointer step wrong");
  a_push_over_limit: assert property (
    i_stk_op == 2'b01 && !i_sp_wr && o_sp > o_limit |-> o_stack_trap && o_trap_over)
    else $error("push beyond limit not trapped");
  a_push_at_limit: assert property (
    i_stk_op == 2'b01 && !i_sp_wr && o_sp == o_limit |-> !o_trap_over)
    else $error("push at limit trapped");
  a_under_floor: assert property (
    i_stk_op == 2'b11 && i_stk_ref_ea < 16'h0800 |-> o_stack_trap && o_trap_under)
    else $error("stack address below floor not trapped");
  a_trap_blocks: assert property (
    o_stack_trap |-> (o_trap_over || o_trap_under) ##1 !o_stk_wr && !o_stk_rd)
    else $error("trap without cause or with strobe");
  a_limit_even: assert property (
    i_limit_wr |=> o_limit == {$past(i_limit_wdata[15:1]), 1'b0})
    else $error("limit load wrong");
  a_table_addr: assert property (
    i_tbl_rd |=> o_prog_rd && o_prog_addr == {$past(i_tbl_page), $past(i_ea)}
      && o_prog_config == $past(i_tbl_page[7]))
    else $error("table address wrong");
  a_cfg_write_reject: assert property (
    i_tbl_wr && i_tbl_page[7] |=> o_tbl_reject && !o_prog_wr)
    else $error("config table write not refused");
  a_win_addr: assert property (
    s_win_req |=> o_win_hit && o_prog_addr == {1'b0, $past(i_vis_page), $past(i_ea[14:1]), 1'b0})
    else $error("window address wrong");
  a_win_read: assert property (
    s_win_req |=> o_prog_rd ##1 s_win_data)
    else $error("window read data wrong");
  a_win_quiet: assert property (
    i_tbl_rd || i_tbl_wr || !i_core_ctrl[2] |=> !o_win_hit)
    else $error("window active when suspended");
  a_win_no_write: assert property (
    i_data_wr && i_ea[15] && i_core_ctrl[2] && !i_tbl_rd && !i_tbl_wr |=> o_win_wr_block
      && !o_prog_wr)
    else $error("window write not blocked");
endmodule
bind scpm_top scpm_top_props #(.DATA_W(DATA_W)) u_scpm_top_props (.*);
`default_nettype wire

/* tb/test_stack_check_and_program_space_map.sv */
// self-checking bench for stack checks and program-space mapping
`timescale 1ns/1ps
`default_nettype none
module test_stack_check_and_program_space_map;
  logic        i_clock = 1'b0, i_rst_b = 1'b0, i_sp_wr = 1'b0, i_limit_wr = 1'b0;
  logic        i_push_call = 1'b0, i_push_exc = 1'b0, i_fetch = 1'b0, i_tbl_rd = 1'b0;
  logic        i_tbl_wr = 1'b0, i_tbl_high = 1'b0, i_tbl_byte = 1'b0, i_data_rd = 1'b0;
  logic        i_data_wr = 1'b0;
  logic [1:0]  i_stk_op = 2'h0;
  logic [7:0]  i_status_low = 8'h00, i_tbl_page = 8'h00, i_vis_page = 8'h00;
  logic [15:0] i_sp_wdata = 16'h0800, i_limit_wdata = 16'h0000, i_stk_ref_ea = 16'h1000;
  logic [15:0] i_push_data = 16'h0000, i_tbl_wdata = 16'h0000, i_ea = 16'h0000;
  logic [15:0] i_core_ctrl = 16'h0000;
  logic [22:0] i_pc = 23'h00_0000;
  logic [23:0] i_prog_rdata, o_prog_addr, o_prog_wdata;
  logic [15:0] o_sp, o_limit, o_stk_addr, o_stk_wdata, o_rdata;
  logic [7:0]  o_stk_wdata_hi;
  logic [2:0]  o_prog_be;
  logic        o_stk_wr, o_stk_rd, o_stack_trap, o_trap_over, o_trap_under, o_prog_rd;
  logic        o_prog_wr, o_prog_config, o_tbl_reject, o_win_hit, o_win_wr_block, o_rvalid;
  int          failures = 0;
  int          tests_run = 0;
  scpm_top u_scpm_top (.*);
  scpm_prog_mem u_scpm_prog_mem (.i_clock(i_clock), .i_rd(o_prog_rd), .i_addr(o_prog_addr),
                                 .o_rdata(i_prog_rdata));
  always #50 i_clock = ~i_clock;
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic load(input logic [15:0] sp, input logic [15:0] lim);
    @(posedge i_clock);
    {i_sp_wr, i_limit_wr, i_sp_wdata, i_limit_wdata} <= {2'b11, sp, lim};
    @(posedge i_clock);
    {i_sp_wr, i_limit_wr} <= 2'b00;
    #1;
  endtask
  // trap is combinational, so it is sampled in the request cycle
  task automatic stk(input logic [1:0] op, input logic call, output logic trap);
    @(posedge i_clock);
    {i_stk_op, i_push_call} <= {op, call};
    #1 trap = o_stack_trap;
    @(posedge i_clock);
    {i_stk_op, i_push_call} <= 3'h0;
    #1;
  endtask
  task automatic prog(input logic [4:0] req, input logic [15:0] ea);
    @(posedge i_clock);
    {i_fetch, i_tbl_rd, i_tbl_wr, i_data_rd, i_data_wr, i_ea} <= {req, ea};
    @(posedge i_clock);
    {i_fetch, i_tbl_rd, i_tbl_wr, i_data_rd, i_data_wr} <= 5'h00;
    #1;
  endtask
  task automatic t_stack();
    logic trap;
    i_push_data <= 16'h3c5a;
    i_stk_ref_ea <= 16'h07fe;
    load(16'h1ffc, 16'h1fff);
    chk_word(o_limit, 16'h1ffe, "limit bit 0");
    stk(2'b01, 1'b0, trap);
    chk_bit(trap, 1'b0, "push below limit");
    chk_bit(o_stk_wr, 1'b1, "push strobe");
    chk_word(o_stk_addr, 16'h1ffc, "push address");
    chk_word(o_stk_wdata, 16'h3c5a, "push data");
    chk_word(o_sp, 16'h1ffe, "pointer after push");
    stk(2'b01, 1'b0, trap);
    chk_bit(trap, 1'b0, "push at limit");
    stk(2'b01, 1'b0, trap);
    chk_bit(trap, 1'b1, "push beyond limit");
    chk_bit(o_stk_wr, 1'b0, "trapped push strobe");
    load(16'h2000, 16'h1ffe);
    stk(2'b10, 1'b0, trap);
    chk_bit(trap, 1'b0, "pop in range");
    chk_bit(o_stk_rd, 1'b1, "pop strobe");
    chk_word(o_stk_addr, 16'h1ffe, "pop address");
    chk_word(o_sp, 16'h1ffe, "pointer after pop");
    load(16'h0800, 16'h1ffe);
    stk(2'b10, 1'b0, trap);
    chk_bit(trap, 1'b1, "pop below floor");
    stk(2'b11, 1'b0, trap);
    chk_bit(trap, 1'b1, "reference below floor");
    $display("test stack done");
  endtask
  task automatic t_call();
    logic trap;
    i_pc <= 23'h7f_1235;
    load(16'h1000, 16'h1ffe);
    stk(2'b01, 1'b1, trap);
    chk_word(o_stk_wdata, 16'h1235, "call low word");
    chk_word(o_stk_wdata_hi, 8'h7f, "call high byte");
    i_push_exc <= 1'b1;
    i_status_low <= 8'ha5;
    stk(2'b01, 1'b0, trap);
    i_push_exc <= 1'b0;
    chk_word(o_stk_wdata, 16'ha57f, "exception frame word");
    prog(5'h10, 16'h0000);
    chk_word(o_prog_addr, 24'h7f_1234, "fetch address");
    $display("test call done");
  endtask
  task automatic t_table();
    i_tbl_page <= 8'h81;
    i_core_ctrl <= 16'h0004;
    prog(5'h0a, 16'hb235);
    chk_word(o_prog_addr, 24'h81_b235, "table read address");
    chk_bit(o_prog_config, 1'b1, "table config");
    chk_bit(o_win_hit, 1'b0, "window during table");
    @(posedge i_clock);
    #1 chk_bit(o_rvalid, 1'b1, "table data valid");
    chk_word(o_rdata, 16'he86f, "table low word");
    prog(5'h04, 16'hb235);
    chk_bit(o_tbl_reject, 1'b1, "config write refused");
    chk_bit(o_prog_wr, 1'b0, "config write strobe");
    i_tbl_page <= 8'h01;
    i_tbl_wdata <= 16'h1234;
    prog(5'h04, 16'h0235);
    chk_word(o_prog_wdata, 24'h34_1234, "user write data");
    chk_word(o_prog_be, 3'b011, "user write lanes");
    chk_bit(o_prog_wr, 1'b1, "user write strobe");
    chk_word(o_prog_addr, 24'h01_0235, "user write address");
    chk_bit(o_prog_config, 1'b0, "user space");
    $display("test table done");
  endtask
  task automatic t_window();
    i_vis_page <= 8'h35;
    prog(5'h02, 16'hf00b);
    chk_bit(o_win_hit, 1'b1, "window hit");
    chk_word(o_prog_addr, 24'h1a_f00a, "window address");
    @(posedge i_clock);
    #1 chk_bit(o_rvalid, 1'b1, "window data valid");
    chk_word(o_rdata, 16'haa50, "window low word");
    prog(5'h01, 16'hf00b);
    chk_bit(o_win_wr_block, 1'b1, "window write blocked");
    i_core_ctrl <= 16'h0000;
    prog(5'h02, 16'hf00b);
    chk_bit(o_win_hit, 1'b0, "window disabled");
    $display("test window done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clock);
    i_rst_b <= 1'b1;
    #1 chk_word(o_sp, 16'h0800, "pointer reset");
    t_stack();
    t_call();
    t_table();
    t_window();
    summarize();
  end
  initial begin
    repeat (1000) @(posedge i_clock);
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
